// ---- drs_cfg.svh ----
// register offsets, field positions, reset values and sizes of the rx bank
`ifndef DRS_CFG_SVH
`define DRS_CFG_SVH

// ----------------------------------------------------------------------
// register offsets (6-bit serial address space)
// ----------------------------------------------------------------------
`define DRS_ADDR_W 6
`define DRS_OFS_CTRL 6'h03
`define DRS_OFS_SERDES_CTL 6'h06
`define DRS_OFS_EVENT_FLAGS 6'h08
`define DRS_OFS_BYTE_A 6'h09
`define DRS_OFS_MASK_A 6'h0A
`define DRS_OFS_BYTE_B 6'h0B
`define DRS_OFS_MASK_B 6'h0C

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define DRS_CTRL_RX_EN_BIT 7
`define DRS_CTRL_TX_EN_BIT 6
`define DRS_EOF_LEN_W 3
`define DRS_FLAGS_PER_CH 4
`define DRS_FLAG_FULL 0
`define DRS_FLAG_EOF 1
`define DRS_FLAG_FLOW 2
`define DRS_FLAG_VALID 3
`define DRS_CMD_WRITE_BIT 7

// ----------------------------------------------------------------------
// reset values and sizes
// ----------------------------------------------------------------------
`define DRS_BYTE_RESET 8'h00
`define DRS_MASK_RESET 8'h00
`define DRS_CTRL_RESET 8'h00
`define DRS_SERDES_CTL_RESET 8'h00
`define DRS_NUM_CH 2
`define DRS_SPI_BITS_CMD 5'h08
`define DRS_SPI_BITS_ALL 5'h10

`endif

// ---- drs_pkg.sv ----
// types shared by the dual receive status bank
`default_nettype none
package drs_pkg;

  // phase of a serial port transfer
  typedef enum logic [1:0] {
    DRS_SPI_CMD,
    DRS_SPI_DATA,
    DRS_SPI_DONE
  } drs_spi_phase_t;

  // one received byte as it leaves a channel receiver
  typedef logic [7:0] drs_byte_t;

endpackage
`default_nettype wire

// ---- drs_rx_chan.sv ----
// bit assembler and end-of-frame detector for one receive channel
`timescale 1ns/100ps
`default_nettype none
`include "drs_cfg.svh"

module drs_rx_chan #(
  parameter int LEN_W = `DRS_EOF_LEN_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // configuration
  input wire logic rx_active,
  input wire logic [LEN_W-1:0] eof_len,
  // bit stream from the correlator
  input wire logic bit_stb,
  input wire logic bit_data,
  input wire logic bit_valid,
  // transfer to the data register
  output logic load_stb,
  output drs_pkg::drs_byte_t load_byte,
  output drs_pkg::drs_byte_t load_mask,
  output logic eof_stb
);
  import drs_pkg::*;

  // ----------------------------------------------------------------------
  // assembly state
  // ----------------------------------------------------------------------
  logic started_q; // a valid bit was seen in this frame
  logic [2:0] pos_q; // next bit slot, first bit over the air at 0
  logic [LEN_W-1:0] inv_q; // invalid bits since the last valid one
  drs_byte_t asm_byte_q;
  drs_byte_t asm_mask_q;
  drs_byte_t asm_byte_d;
  drs_byte_t asm_mask_d;
  logic eof_hit;

  // slot the incoming bit into the partial byte; invalid bits keep a hole
  always_comb begin
    asm_byte_d = asm_byte_q;
    asm_mask_d = asm_mask_q;
    asm_byte_d[pos_q] = bit_data & bit_valid;
    asm_mask_d[pos_q] = bit_valid;
  end

  // the gap exceeds the length; a zero length fires on the first gap bit
  assign eof_hit = bit_stb && !bit_valid && started_q
    && (inv_q >= eof_len);

  // ----------------------------------------------------------------------
  // receive sequencing
  // ----------------------------------------------------------------------
  // leaving receive mode drops any half built byte, by design
  always_ff @(posedge ref_clk) begin
    load_stb <= 1'b0;
    eof_stb <= 1'b0;
    if (!rst_b || !rx_active) begin
      started_q <= 1'b0;
      pos_q <= 3'h0;
      inv_q <= '0;
      asm_byte_q <= `DRS_BYTE_RESET;
      asm_mask_q <= `DRS_MASK_RESET;
      load_byte <= `DRS_BYTE_RESET;
      load_mask <= `DRS_MASK_RESET;
    end else if (eof_hit) begin
      // frame over: hand on a partial byte if any slot was used
      eof_stb <= 1'b1;
      load_stb <= (pos_q != 3'h0);
      load_byte <= asm_byte_q;
      load_mask <= asm_mask_q;
      started_q <= 1'b0;
      pos_q <= 3'h0;
      inv_q <= '0;
      asm_byte_q <= `DRS_BYTE_RESET;
      asm_mask_q <= `DRS_MASK_RESET;
    end else if (bit_stb && (bit_valid || started_q)) begin
      started_q <= 1'b1;
      inv_q <= bit_valid ? '0 : inv_q + 1'b1;
      pos_q <= pos_q + 3'h1;
      if (pos_q == 3'h7) begin
        // complete byte
        load_stb <= 1'b1;
        load_byte <= asm_byte_d;
        load_mask <= asm_mask_d;
        asm_byte_q <= `DRS_BYTE_RESET;
        asm_mask_q <= `DRS_MASK_RESET;
      end else begin
        asm_byte_q <= asm_byte_d;
        asm_mask_q <= asm_mask_d;
      end
    end
  end

endmodule // drs_rx_chan
`default_nettype wire

// ---- drs_regs.sv ----
// receive status register bank for two channels behind a serial port
`timescale 1ns/100ps
`default_nettype none
`include "drs_cfg.svh"

module drs_regs (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // serial register port (mode 0, msb first)
  input wire logic spi_sck,
  input wire logic spi_ss_b,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  // channel A bit stream
  input wire logic rxa_bit_stb,
  input wire logic rxa_bit_data,
  input wire logic rxa_bit_valid,
  // channel B bit stream
  input wire logic rxb_bit_stb,
  input wire logic rxb_bit_data,
  input wire logic rxb_bit_valid,
  // receive mode seen by the rest of the radio
  output logic rx_mode
);
  import drs_pkg::*;

  localparam int NCH = `DRS_NUM_CH;
  localparam int FW = `DRS_FLAGS_PER_CH;

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic sck_s1, sck_s2, sck_s3; // s1 feeds s2 only
  logic ss_s1, ss_s2; // chip select, active low
  logic mosi_s1, mosi_s2;

  // the port pins belong to the host's timing, so two stages each
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      ss_s1 <= 1'b1;
      ss_s2 <= 1'b1;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
    end else begin
      sck_s1 <= spi_sck;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      ss_s1 <= spi_ss_b;
      ss_s2 <= ss_s1;
      mosi_s1 <= spi_mosi;
      mosi_s2 <= mosi_s1;
    end
  end

  logic sck_rise; // sample edge
  logic sck_fall; // shift-out edge
  assign sck_rise = sck_s2 && !sck_s3 && !ss_s2;
  assign sck_fall = !sck_s2 && sck_s3 && !ss_s2;

  // ----------------------------------------------------------------------
  // serial transfer sequencing
  // ----------------------------------------------------------------------
  drs_spi_phase_t phase_q;
  logic [4:0] bit_cnt_q; // bits sampled in this transfer
  logic [7:0] shin_q; // incoming shift register
  logic [7:0] shout_q; // outgoing shift register
  logic [`DRS_ADDR_W-1:0] addr_q; // register addressed by the command
  logic wr_cmd_q; // command asked for a write
  logic rd_stb; // one-cycle read side-effect pulse
  logic wr_stb; // one-cycle write pulse
  logic [7:0] shin_next;
  logic [7:0] rd_value;

  assign shin_next = {shin_q[6:0], mosi_s2};
  assign rd_stb = sck_rise && (phase_q == DRS_SPI_CMD)
    && (bit_cnt_q == `DRS_SPI_BITS_CMD - 5'h1)
    && !shin_next[`DRS_CMD_WRITE_BIT];
  assign wr_stb = sck_rise && (phase_q == DRS_SPI_DATA)
    && (bit_cnt_q == `DRS_SPI_BITS_ALL - 5'h1) && wr_cmd_q;

  // command byte, then one data byte; extra clocks are ignored
  always_ff @(posedge ref_clk) begin
    if (!rst_b || ss_s2) begin
      phase_q <= DRS_SPI_CMD;
      bit_cnt_q <= 5'h00;
      shin_q <= 8'h00;
      addr_q <= '0;
      wr_cmd_q <= 1'b0;
    end else if (sck_rise) begin
      shin_q <= shin_next;
      case (phase_q)
        DRS_SPI_CMD: begin
          bit_cnt_q <= bit_cnt_q + 5'h01;
          if (bit_cnt_q == `DRS_SPI_BITS_CMD - 5'h1) begin
            phase_q <= DRS_SPI_DATA;
            addr_q <= shin_next[`DRS_ADDR_W-1:0];
            wr_cmd_q <= shin_next[`DRS_CMD_WRITE_BIT];
          end
        end
        DRS_SPI_DATA: begin
          bit_cnt_q <= bit_cnt_q + 5'h01;
          if (bit_cnt_q == `DRS_SPI_BITS_ALL - 5'h1) begin
            phase_q <= DRS_SPI_DONE;
          end
        end
        default: begin
          phase_q <= DRS_SPI_DONE;
        end
      endcase
    end
  end

  // read data is captured once, at the end of the command byte
  always_ff @(posedge ref_clk) begin
    if (!rst_b || ss_s2) begin
      shout_q <= 8'h00;
      spi_miso <= 1'b0;
    end else if (rd_stb) begin
      shout_q <= rd_value;
    end else if (sck_fall && (phase_q == DRS_SPI_DATA)) begin
      spi_miso <= shout_q[7];
      shout_q <= {shout_q[6:0], 1'b0};
    end
  end

  // drive the data-out pin only while selected
  assign spi_miso_oe = !ss_s2;

  // ----------------------------------------------------------------------
  // writable configuration
  // ----------------------------------------------------------------------
  logic [7:0] ctrl_q; // rx and tx enables in bits 7:6
  logic [7:0] serdes_ctl_q; // end-of-frame length in low bits

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ctrl_q <= `DRS_CTRL_RESET;
      serdes_ctl_q <= `DRS_SERDES_CTL_RESET;
    end else if (wr_stb) begin
      if (addr_q == `DRS_OFS_CTRL) begin
        ctrl_q <= shin_next;
      end else if (addr_q == `DRS_OFS_SERDES_CTL) begin
        serdes_ctl_q <= shin_next;
      end
      // status, data and mask registers ignore writes
    end
  end

  assign rx_mode = ctrl_q[`DRS_CTRL_RX_EN_BIT];

  // ----------------------------------------------------------------------
  // per channel receivers and flags
  // ----------------------------------------------------------------------
  logic [NCH-1:0] bit_stb_v, bit_data_v, bit_valid_v;
  logic [NCH*FW-1:0] flags_all; // channel c in nibble c
  drs_byte_t byte_all [NCH];
  drs_byte_t mask_all [NCH];
  logic rd_flags; // status register read
  logic [`DRS_ADDR_W-1:0] byte_ofs [NCH];

  assign bit_stb_v = {rxb_bit_stb, rxa_bit_stb};
  assign bit_data_v = {rxb_bit_data, rxa_bit_data};
  assign bit_valid_v = {rxb_bit_valid, rxa_bit_valid};
  assign byte_ofs[0] = `DRS_OFS_BYTE_A;
  assign byte_ofs[1] = `DRS_OFS_BYTE_B;
  assign rd_flags = rd_stb && (shin_next[`DRS_ADDR_W-1:0]
    == `DRS_OFS_EVENT_FLAGS);

  genvar c;
  generate
    for (c = 0; c < NCH; c = c + 1) begin : g_ch
      logic load_stb, eof_stb;
      drs_byte_t load_byte, load_mask;
      logic rd_byte; // this channel's data register read
      logic full_q, eof_q, flow_q, valid_q;
      drs_byte_t byte_q, mask_q;

      drs_rx_chan #(
        .LEN_W(`DRS_EOF_LEN_W)
      ) u_rx (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .rx_active(rx_mode),
        .eof_len(serdes_ctl_q[`DRS_EOF_LEN_W-1:0]),
        .bit_stb(bit_stb_v[c]),
        .bit_data(bit_data_v[c]),
        .bit_valid(bit_valid_v[c]),
        .load_stb(load_stb),
        .load_byte(load_byte),
        .load_mask(load_mask),
        .eof_stb(eof_stb)
      );

      assign rd_byte = rd_stb
        && (shin_next[`DRS_ADDR_W-1:0] == byte_ofs[c]);

      // data and mask hold the last transfer from the receiver
      always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
          byte_q <= `DRS_BYTE_RESET;
          mask_q <= `DRS_MASK_RESET;
        end else if (load_stb) begin
          byte_q <= load_byte;
          mask_q <= load_mask;
        end
      end

      // event flags: in every branch a hardware set beats a read clear
      always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
          full_q <= 1'b0;
          eof_q <= 1'b0;
          flow_q <= 1'b0;
          valid_q <= 1'b0;
        end else begin
          // full follows every transfer, enables play no part
          if (load_stb) begin
            full_q <= 1'b1;
          end else if (rd_byte || rd_flags) begin
            full_q <= 1'b0;
          end
          // overrun on load, or underrun on a read of an empty register
          if ((load_stb && full_q) || (rd_byte && !full_q)) begin
            flow_q <= 1'b1;
          end else if (rd_flags) begin
            flow_q <= 1'b0;
          end
          if (eof_stb) begin
            eof_q <= 1'b1;
          end else if (rd_flags) begin
            eof_q <= 1'b0;
          end
          // valid tracks each loaded byte and never clears on read
          if (load_stb) begin
            valid_q <= &load_mask;
          end
        end
      end

      assign flags_all[c*FW +: FW] = {valid_q, flow_q, eof_q, full_q};
      assign byte_all[c] = byte_q;
      assign mask_all[c] = mask_q;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------------
  logic [`DRS_ADDR_W-1:0] rd_addr;
  assign rd_addr = shin_next[`DRS_ADDR_W-1:0];

  // outside receive mode the receivers are held idle and a status read still clears the full, eof and flow flags, only the view is masked
  always_comb begin
    if (rd_addr == `DRS_OFS_EVENT_FLAGS) begin
      rd_value = rx_mode ? flags_all : 8'h00;
    end else if (rd_addr == `DRS_OFS_BYTE_A) begin
      rd_value = byte_all[0];
    end else if (rd_addr == `DRS_OFS_MASK_A) begin
      rd_value = mask_all[0];
    end else if (rd_addr == `DRS_OFS_BYTE_B) begin
      rd_value = byte_all[1];
    end else if (rd_addr == `DRS_OFS_MASK_B) begin
      rd_value = mask_all[1];
    end else if (rd_addr == `DRS_OFS_CTRL) begin
      rd_value = ctrl_q;
    end else if (rd_addr == `DRS_OFS_SERDES_CTL) begin
      rd_value = serdes_ctl_q;
    end else begin
      rd_value = 8'h00; // unmapped reads as zero
    end
  end

endmodule // drs_regs
`default_nettype wire

// ---- drs_regs_sva.sv ----
// port checker for the dual receive status bank
`timescale 1ns/100ps
`default_nettype none
`include "drs_cfg.svh"

module drs_regs_sva (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // serial port
  input wire logic spi_sck,
  input wire logic spi_ss_b,
  input wire logic spi_mosi,
  input wire logic spi_miso,
  input wire logic spi_miso_oe,
  // receivers and mode
  input wire logic rxa_bit_stb,
  input wire logic rxb_bit_stb,
  input wire logic rx_mode
);
  // ----------------------------------------------------------------
  // transfer decode
  // ----------------------------------------------------------------
  logic [4:0] cnt_q; // sck rises in this select
  logic [15:0] sh_q; // command and data from host
  logic [7:0] rd_q; // bits seen on miso
  logic ss_q;
  logic sck_q;
  always_ff @(posedge ref_clk) begin
    ss_q <= spi_ss_b;
    sck_q <= spi_sck;
    if (!rst_b || spi_ss_b) begin
      cnt_q <= 5'h00;
    end else if (spi_sck && !sck_q && cnt_q != 5'h10) begin
      cnt_q <= cnt_q + 5'h01;
      sh_q <= {sh_q[14:0], spi_mosi};
      rd_q <= {rd_q[6:0], spi_miso};
    end
  end
  wire done = spi_ss_b && !ss_q && cnt_q == 5'h10;
  wire rd = done && !sh_q[15];
  wire [5:0] adr = sh_q[13:8];
  wire st_rd = rd && adr == `DRS_OFS_EVENT_FLAGS;
  wire stb = rxa_bit_stb || rxb_bit_stb;
  // ----------------------------------------------------------------
  // history since the last status read
  // ----------------------------------------------------------------
  // armed: flags untouched by the radio since a status read, so the
  // read's clears are visible; a write may change mode, so it disarms
  logic armed_q;
  logic dra_q; // data A read since status read
  logic drx_q; // any data read since status read
  logic fresh_q; // no bit since reset
  logic [7:0] st_q; // last status value
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      armed_q <= 1'b0;
      dra_q <= 1'b0;
      drx_q <= 1'b0;
      fresh_q <= 1'b1;
      st_q <= 8'h00;
    end else begin
      if (stb || (done && sh_q[15])) armed_q <= 1'b0;
      else if (st_rd) armed_q <= rx_mode;
      if (stb) fresh_q <= 1'b0;
      if (st_rd) begin
        dra_q <= 1'b0;
        drx_q <= 1'b0;
        st_q <= rd_q;
      end else if (rd && adr == `DRS_OFS_BYTE_A) begin
        dra_q <= 1'b1;
        drx_q <= 1'b1;
      end else if (rd && adr == `DRS_OFS_BYTE_B) begin
        drx_q <= 1'b1;
      end
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_status_gated:
    assert property (st_rd && !rx_mode |-> rd_q == 8'h00)
    else $error("status not zero outside receive mode");
  a_flags_cleared:
    assert property (st_rd && armed_q && !drx_q |-> (rd_q & 8'h77) == 8'h00)
    else $error("status read left a clearable flag");
  a_valid_kept:
    assert property (st_rd && armed_q
      |-> {rd_q[7], rd_q[3]} == {st_q[7], st_q[3]})
    else $error("whole byte flag changed without a load");
  a_underflow_seen:
    assert property (st_rd && armed_q && dra_q |-> rd_q[2])
    else $error("empty data read not flagged");
  a_mask_a_whole:
    assert property (rd && armed_q && st_q[3] && adr == `DRS_OFS_MASK_A
      |-> rd_q == 8'hFF)
    else $error("mask A not full with whole flag");
  a_mask_b_whole:
    assert property (rd && armed_q && st_q[7] && adr == `DRS_OFS_MASK_B
      |-> rd_q == 8'hFF)
    else $error("mask B not full with whole flag");
  a_reset_zero:
    assert property (rd && fresh_q && adr >= `DRS_OFS_BYTE_A
      && adr <= `DRS_OFS_MASK_B |-> rd_q == 8'h00)
    else $error("data or mask not zero after reset");
  a_mode_write:
    assert property (done && sh_q[15] && adr == `DRS_OFS_CTRL
      |-> rx_mode == sh_q[7])
    else $error("receive mode not taken from control write");
  a_oe_select:
    assert property (spi_ss_b [*3] |-> !spi_miso_oe)
    else $error("miso driven while not selected");
  c_underflow: cover property (st_rd && armed_q && dra_q);
  c_mask_whole: cover property (rd && armed_q && st_q[3]);
  c_write: cover property (done && sh_q[15]);
endmodule // drs_regs_sva

bind drs_regs drs_regs_sva chk (.ref_clk(ref_clk), .rst_b(rst_b),
  .spi_sck(spi_sck), .spi_ss_b(spi_ss_b), .spi_mosi(spi_mosi),
  .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
  .rxa_bit_stb(rxa_bit_stb), .rxb_bit_stb(rxb_bit_stb),
  .rx_mode(rx_mode));
`default_nettype wire

// ---- drs_host_model.sv ----
// host side serial port model that reads and writes the bank
`timescale 1ns/100ps
`default_nettype none

module drs_host_model (
  // clock from the bench
  input wire logic ref_clk,
  // serial port towards the bank
  output logic spi_sck,
  output logic spi_ss_b,
  output logic spi_mosi,
  input wire logic spi_miso,
  input wire logic spi_miso_oe
);
  // ----------------------------------------------------------------
  // idle: clock low, select high
  // ----------------------------------------------------------------
  initial begin
    spi_sck = 1'b0;
    spi_ss_b = 1'b1;
    spi_mosi = 1'b0;
  end
  // command byte then data byte, msb first; each sck half lasts over
  // four clocks so the bank's synchroniser never misses an edge
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd,
                      output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, wd};
    rd = 8'h00;
    @(negedge ref_clk);
    spi_ss_b = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(negedge ref_clk);
      spi_mosi = sh[i];
      repeat (5) @(negedge ref_clk);
      spi_sck = 1'b1;
      // miso has a pull-up, so an undriven line reads high
      if (i < 8) rd = {rd[6:0], spi_miso_oe ? spi_miso : 1'b1};
      repeat (5) @(negedge ref_clk);
      spi_sck = 1'b0;
    end
    repeat (5) @(negedge ref_clk);
    spi_ss_b = 1'b1;
    // a released line keeps no meaningful value
    spi_mosi = ~spi_mosi;
    repeat (4) @(negedge ref_clk);
  endtask
endmodule // drs_host_model
`default_nettype wire

// ---- drs_regs_tb_top.sv ----
// self-checking bench for the dual receive status bank
`timescale 1ns/100ps
`default_nettype none

`define CHK(n, e, g) begin \
  checked++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("mismatch %s expected %h seen %h", n, e, g); \
  end \
end

module drs_regs_tb_top;
  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic rxa_bit_stb = 1'b0;
  logic rxa_bit_data = 1'b0;
  logic rxa_bit_valid = 1'b0;
  logic rxb_bit_stb = 1'b0;
  logic rxb_bit_data = 1'b0;
  logic rxb_bit_valid = 1'b0;
  logic spi_sck;
  logic spi_ss_b;
  logic spi_mosi;
  logic spi_miso;
  logic spi_miso_oe;
  logic rx_mode;
  int num_errors = 0;
  int checked = 0;
  // 20 MHz
  always #25 ref_clk = ~ref_clk;
  drs_regs uut (.ref_clk(ref_clk), .rst_b(rst_b), .spi_sck(spi_sck),
    .spi_ss_b(spi_ss_b), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .rxa_bit_stb(rxa_bit_stb),
    .rxa_bit_data(rxa_bit_data), .rxa_bit_valid(rxa_bit_valid),
    .rxb_bit_stb(rxb_bit_stb), .rxb_bit_data(rxb_bit_data),
    .rxb_bit_valid(rxb_bit_valid), .rx_mode(rx_mode));
  drs_host_model host (.ref_clk(ref_clk), .spi_sck(spi_sck),
    .spi_ss_b(spi_ss_b), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] r;
    host.xfer({2'b10, a}, d, r);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] r;
    host.xfer({2'b00, a}, 8'h00, r);
    `CHK($sformatf("reg_%h", a), e, r)
  endtask
  // n bits lsb first on one channel; qualifiers flip outside strobes
  task automatic send(input logic ch, input logic [7:0] d,
                      input logic [7:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge ref_clk);
      rxa_bit_data = d[i];
      rxb_bit_data = d[i];
      rxa_bit_valid = v[i];
      rxb_bit_valid = v[i];
      rxa_bit_stb = !ch;
      rxb_bit_stb = ch;
      @(negedge ref_clk);
      rxa_bit_stb = 1'b0;
      rxb_bit_stb = 1'b0;
      rxa_bit_valid = !v[i];
      rxb_bit_valid = !v[i];
    end
    repeat (4) @(negedge ref_clk);
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge ref_clk);
    for (int a = 9; a <= 12; a++) rd_chk(6'(a), 8'h00);
    rd_chk(6'h08, 8'h00);
    wr(6'h03, 8'h80);
    `CHK("rx_mode", 1'b1, rx_mode)
    send(1'b0, 8'hA5, 8'hFF, 8);
    rd_chk(6'h08, 8'h09);
    rd_chk(6'h09, 8'hA5);
    rd_chk(6'h0A, 8'hFF);
    rd_chk(6'h08, 8'h0C);
    rd_chk(6'h08, 8'h08);
    send(1'b0, 8'h3C, 8'hFF, 8);
    send(1'b0, 8'hC3, 8'hFF, 8);
    rd_chk(6'h09, 8'hC3);
    rd_chk(6'h08, 8'h0C);
    wr(6'h06, 8'h02);
    rd_chk(6'h06, 8'h02);
    send(1'b1, 8'h1D, 8'h07, 6);
    rd_chk(6'h08, 8'h38);
    rd_chk(6'h0B, 8'h05);
    rd_chk(6'h0C, 8'h07);
    rd_chk(6'h08, 8'h48);
    wr(6'h06, 8'h00);
    send(1'b0, 8'h03, 8'h03, 3);
    rd_chk(6'h08, 8'h03);
    rd_chk(6'h09, 8'h03);
    rd_chk(6'h0A, 8'h03);
    rd_chk(6'h08, 8'h04);
    send(1'b1, 8'hFF, 8'hFF, 8);
    rd_chk(6'h08, 8'h90);
    rd_chk(6'h0C, 8'hFF);
    wr(6'h0B, 8'h55);
    rd_chk(6'h0B, 8'hFF);
    wr(6'h03, 8'h40);
    `CHK("rx_mode", 1'b0, rx_mode)
    rd_chk(6'h03, 8'h40);
    rd_chk(6'h08, 8'h00);
    rd_chk(6'h3F, 8'h00);
    final_report();
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge ref_clk);
    num_errors++;
    final_report();
  end
endmodule // drs_regs_tb_top
`default_nettype wire
